//--- core/ccmr_pkg.sv
// Constants for the charger compensation and misc control register pair.
// Assumes an I2C slave engine delivers decoded register accesses on SYS_CLK.
// Operation
// - Compensation resistance 10/20/40 mohm per bit, reset 000
// - Clamp bits 16/32/64 mV, 0-112 mV, reset 0
// - Thermal threshold 60/80/100/120 C, reset 11
// - Force detect bit self-clears when detection completes
// - Half-speed bit slows safety timer while limiting or thermal regulating
// - Switch-off bit turns battery switch transistor off
// - Warm band bit lowers charge target 200 mV
// - Mask bit1 gates charge fault interrupt
// - Mask bit0 gates battery fault interrupt
// - Misc register resets to 8'h4b
package ccmr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses and reset values
  localparam logic [7:0] ADDR_IR_COMP_THERMAL_CTRL = 8'h06;
  localparam logic [7:0] ADDR_MISC_OPERATION_CTRL  = 8'h07;
  localparam logic [7:0] RST_IR_COMP_THERMAL_CTRL  = 8'h03;
  localparam logic [7:0] RST_MISC_OPERATION_CTRL   = 8'h4b;
  localparam logic [7:0] RDATA_UNMAPPED            = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions, ir_comp_thermal_ctrl
  localparam int RES_MSB   = 7;
  localparam int RES_LSB   = 5;
  localparam int CLAMP_MSB = 4;
  localparam int CLAMP_LSB = 2;
  localparam int THERM_MSB = 1;
  localparam int THERM_LSB = 0;

  // Field positions, misc_operation_ctrl
  localparam int BIT_FORCE_DETECT = 7;
  localparam int BIT_HALF_SPEED   = 6;
  localparam int BIT_SWITCH_OFF   = 5;
  localparam int BIT_WARM_REDUCE  = 4;
  localparam int BIT_RSVD_ONE     = 3;
  localparam int BIT_RSVD_ZERO    = 2;
  localparam int BIT_MASK_CHARGE  = 1;
  localparam int BIT_MASK_BATTERY = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded setting weights
  localparam logic [6:0] RES_STEP_MOHM    = 7'h0a;  // 10 mohm per code step
  localparam logic [6:0] CLAMP_STEP_MV    = 7'h10;  // 16 mV per code step
  localparam logic [6:0] THERM_BASE_DEGC  = 7'h3c;  // 60 C at code 00
  localparam logic [6:0] THERM_STEP_DEGC  = 7'h14;  // 20 C per code step
  localparam logic [7:0] WARM_REDUCE_MV   = 8'hc8;  // 200 mV
  localparam logic [7:0] NO_REDUCE_MV     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Safety timer base tick
  localparam int         CLK_PERIOD_PS    = 4000;
  localparam int         BASE_TICK_NS     = 1000;
  localparam int         BASE_TICK_CYCLES = (BASE_TICK_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [9:0] BASE_TICK_LAST   = 10'(BASE_TICK_CYCLES - 1);

  // Synchronised input vector positions
  localparam int SYN_DETECT_DONE  = 0;
  localparam int SYN_CHARGE_FAULT = 1;
  localparam int SYN_BATT_FAULT   = 2;
  localparam int SYN_INPUT_LIMIT  = 3;
  localparam int SYN_THERMAL_REG  = 4;
  localparam int SYN_WARM_BAND    = 5;
  localparam int SYN_WIDTH        = 6;

endpackage

//--- core/ccmr_safety_tick.sv
// Safety timer tick generator with optional half-rate operation.
// Assumes slow_request already synchronised to SYS_CLK.
`timescale 1ns/1ps
module ccmr_safety_tick
  import ccmr_pkg::*;
(
  input  wire logic SYS_CLK,
  input  wire logic RESET,
  input  wire logic slow_request,
  output logic      tick
);

  logic [9:0] cnt_ff;
  logic [9:0] nxt_cnt;
  logic       phase_ff;
  logic       nxt_phase;
  logic       tick_ff;
  logic       nxt_tick;
  logic       base;

  ////////////////////////////////////////////////////////////////////////////
  // Base divider and half-rate gating
  always_comb begin
    base      = (cnt_ff == BASE_TICK_LAST);
    nxt_cnt   = base ? 10'h000 : cnt_ff + 10'h001;
    nxt_phase = phase_ff;
    nxt_tick  = 1'b0;
    if (base) begin
      nxt_phase = ~phase_ff;
      nxt_tick  = ~slow_request | phase_ff;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      cnt_ff   <= 10'h000;
      phase_ff <= 1'b0;
      tick_ff  <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      phase_ff <= nxt_phase;
      tick_ff  <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule

//--- core/ccmr_regs.sv
// Compensation/thermal and misc operation control registers, with decoded
// settings, warm band target reduction, fault interrupt pulse and safety tick.
// Assumes an I2C slave engine on SYS_CLK issuing one-cycle read/write strobes;
// status levels come from the analog side and are synchronised here.
// Assumes the detection engine raises DETECT_DONE once per completed run.
`timescale 1ns/1ps
module ccmr_regs
  import ccmr_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       RESET,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  input  wire logic       DETECT_DONE,
  input  wire logic       CHARGE_FAULT_FLAG,
  input  wire logic       BATTERY_FAULT_FLAG,
  input  wire logic       INPUT_POWER_LIMITING,
  input  wire logic       THERMAL_REGULATION,
  input  wire logic       WARM_BAND,
  output logic      [2:0] IR_COMP_RESISTANCE,
  output logic      [6:0] IR_COMP_RESISTANCE_MOHM,
  output logic      [2:0] IR_COMP_VOLTAGE_CLAMP,
  output logic      [6:0] IR_COMP_CLAMP_MV,
  output logic      [1:0] THERMAL_REG_THRESHOLD,
  output logic      [6:0] THERMAL_THRESHOLD_DEGC,
  output logic            FORCE_PORT_DETECT,
  output logic            BATTERY_SWITCH_OFF,
  output logic      [7:0] CHARGE_VOLTAGE_REDUCE_MV,
  output logic            SAFETY_TIMER_TICK,
  output logic            FAULT_INT
);

  // Status synchroniser chain and edge history
  logic [SYN_WIDTH-1:0] raw_in;
  logic [SYN_WIDTH-1:0] syn1_ff;
  logic [SYN_WIDTH-1:0] nxt_syn1;
  logic [SYN_WIDTH-1:0] syn2_ff;
  logic [SYN_WIDTH-1:0] nxt_syn2;
  logic [SYN_WIDTH-1:0] prev_ff;
  logic [SYN_WIDTH-1:0] nxt_prev;

  // Register images and read data
  logic [7:0]           comp_ff;
  logic [7:0]           nxt_comp;
  logic [7:0]           misc_ff;
  logic [7:0]           nxt_misc;
  logic [7:0]           rdata_ff;
  logic [7:0]           nxt_rdata;

  // Decoded settings and interrupt pulse
  logic [6:0]           res_mohm_ff;
  logic [6:0]           nxt_res_mohm;
  logic [6:0]           clamp_mv_ff;
  logic [6:0]           nxt_clamp_mv;
  logic [6:0]           therm_degc_ff;
  logic [6:0]           nxt_therm_degc;
  logic [7:0]           reduce_ff;
  logic [7:0]           nxt_reduce;
  logic                 int_ff;
  logic                 nxt_int;

  // Decoded strobes and events
  logic                 wr_comp;
  logic                 wr_misc;
  logic                 detect_done_rise;
  logic                 charge_fault_rise;
  logic                 batt_fault_rise;
  logic                 slow_request;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for analog status levels
  assign raw_in = {WARM_BAND, THERMAL_REGULATION, INPUT_POWER_LIMITING,
                   BATTERY_FAULT_FLAG, CHARGE_FAULT_FLAG, DETECT_DONE};

  // Next stage values; only stage 2 reads stage 1
  assign nxt_syn1 = raw_in;
  assign nxt_syn2 = syn1_ff;
  assign nxt_prev = syn2_ff;

  genvar gi;
  generate
    for (gi = 0; gi < SYN_WIDTH; gi++) begin : g_sync
      // One flop per stage per status bit
      always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
          syn1_ff[gi] <= 1'b0;
          syn2_ff[gi] <= 1'b0;
          prev_ff[gi] <= 1'b0;
        end else begin
          syn1_ff[gi] <= nxt_syn1[gi];
          syn2_ff[gi] <= nxt_syn2[gi];
          prev_ff[gi] <= nxt_prev[gi];
        end
      end
    end
  endgenerate

  // Rising edges of synchronised levels
  assign detect_done_rise  = syn2_ff[SYN_DETECT_DONE]  & ~prev_ff[SYN_DETECT_DONE];
  assign charge_fault_rise = syn2_ff[SYN_CHARGE_FAULT] & ~prev_ff[SYN_CHARGE_FAULT];
  assign batt_fault_rise   = syn2_ff[SYN_BATT_FAULT]   & ~prev_ff[SYN_BATT_FAULT];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and reads
  assign wr_comp = REG_WR & (REG_ADDR == ADDR_IR_COMP_THERMAL_CTRL);
  assign wr_misc = REG_WR & (REG_ADDR == ADDR_MISC_OPERATION_CTRL);

  // Next register images: host writes and detect self-clear
  always_comb begin
    nxt_comp = wr_comp ? REG_WDATA : comp_ff;
    // misc bits hold written value, except force detect, which clears on detection done
    nxt_misc = wr_misc ? REG_WDATA : misc_ff;
    if (detect_done_rise && !(wr_misc && REG_WDATA[BIT_FORCE_DETECT])) begin
      nxt_misc[BIT_FORCE_DETECT] = 1'b0;
    end
  end

  // Register images, loaded with their reset values
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      comp_ff <= RST_IR_COMP_THERMAL_CTRL;
      misc_ff <= RST_MISC_OPERATION_CTRL;
    end else begin
      comp_ff <= nxt_comp;
      misc_ff <= nxt_misc;
    end
  end

  // Read mux; a read in a write cycle returns the old image
  always_comb begin
    nxt_rdata = rdata_ff;
    if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_IR_COMP_THERMAL_CTRL: nxt_rdata = comp_ff;
        ADDR_MISC_OPERATION_CTRL:  nxt_rdata = misc_ff;
        default:                   nxt_rdata = RDATA_UNMAPPED;
      endcase
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rdata_ff <= RDATA_UNMAPPED;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded settings and fault interrupt
  always_comb begin
    // binary weighted resistance, 10 mohm step
    nxt_res_mohm  = 7'(RES_STEP_MOHM * 7'(comp_ff[RES_MSB:RES_LSB]));
    nxt_clamp_mv  = 7'(CLAMP_STEP_MV * 7'(comp_ff[CLAMP_MSB:CLAMP_LSB]));
    nxt_therm_degc = 7'(THERM_BASE_DEGC + THERM_STEP_DEGC * 7'(comp_ff[THERM_MSB:THERM_LSB]));
    nxt_reduce    = (syn2_ff[SYN_WARM_BAND] && misc_ff[BIT_WARM_REDUCE]) ? WARM_REDUCE_MV : NO_REDUCE_MV;
    nxt_int       = charge_fault_rise & misc_ff[BIT_MASK_CHARGE];
    if (batt_fault_rise && misc_ff[BIT_MASK_BATTERY]) begin
      nxt_int = 1'b1;
    end
  end

  // Decoded outputs lag their field by one cycle
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      res_mohm_ff   <= 7'h00;
      clamp_mv_ff   <= 7'h00;
      therm_degc_ff <= 7'h00;
      reduce_ff     <= NO_REDUCE_MV;
      int_ff        <= 1'b0;
    end else begin
      res_mohm_ff   <= nxt_res_mohm;
      clamp_mv_ff   <= nxt_clamp_mv;
      therm_degc_ff <= nxt_therm_degc;
      reduce_ff     <= nxt_reduce;
      int_ff        <= nxt_int;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Safety timer tick
  // slow only while limiting or regulating
  assign slow_request = misc_ff[BIT_HALF_SPEED] &
                        (syn2_ff[SYN_INPUT_LIMIT] | syn2_ff[SYN_THERMAL_REG]);

  // Base divider with half-rate gating
  ccmr_safety_tick i_ccmr_safety_tick (
    .SYS_CLK      (SYS_CLK),
    .RESET        (RESET),
    .slow_request (slow_request),
    .tick         (SAFETY_TIMER_TICK)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output drive
  assign REG_RDATA                = rdata_ff;
  assign IR_COMP_RESISTANCE       = comp_ff[RES_MSB:RES_LSB];
  assign IR_COMP_VOLTAGE_CLAMP    = comp_ff[CLAMP_MSB:CLAMP_LSB];
  assign THERMAL_REG_THRESHOLD    = comp_ff[THERM_MSB:THERM_LSB];

  // Decoded values, registered
  assign IR_COMP_RESISTANCE_MOHM  = res_mohm_ff;
  assign IR_COMP_CLAMP_MV         = clamp_mv_ff;
  assign THERMAL_THRESHOLD_DEGC   = therm_degc_ff;

  // Misc control levels and pulses
  assign FORCE_PORT_DETECT        = misc_ff[BIT_FORCE_DETECT];
  assign BATTERY_SWITCH_OFF       = misc_ff[BIT_SWITCH_OFF];
  assign CHARGE_VOLTAGE_REDUCE_MV = reduce_ff;
  assign FAULT_INT                = int_ff;

endmodule

//--- tb/ccmr_assertions.sv
// Checker for the compensation and misc control registers.
// Assumes it is bound to ccmr_regs and sees only its ports.
`timescale 1ns/1ps
module ccmr_assertions (
  input wire logic       SYS_CLK,
  input wire logic       RESET,
  input wire logic [7:0] REG_ADDR,
  input wire logic       REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic       CHARGE_FAULT_FLAG,
  input wire logic       BATTERY_FAULT_FLAG,
  input wire logic [2:0] IR_COMP_RESISTANCE,
  input wire logic [6:0] IR_COMP_RESISTANCE_MOHM,
  input wire logic [2:0] IR_COMP_VOLTAGE_CLAMP,
  input wire logic [1:0] THERMAL_REG_THRESHOLD,
  input wire logic       FORCE_PORT_DETECT,
  input wire logic       BATTERY_SWITCH_OFF,
  input wire logic       FAULT_INT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // Decoded accesses and readback image
  wire       w6 = REG_WR && (REG_ADDR == 8'h06);
  wire       w7 = REG_WR && (REG_ADDR == 8'h07);
  wire       wd = w7 && REG_WDATA[7];
  wire [7:0] f6 = {IR_COMP_RESISTANCE, IR_COMP_VOLTAGE_CLAMP, THERMAL_REG_THRESHOLD};
  a_res_write: assert property (w6 |=> IR_COMP_RESISTANCE == $past(REG_WDATA[7:5]))
    else $error("resistance field not written");
  a_clamp_write: assert property (w6 |=> IR_COMP_VOLTAGE_CLAMP == $past(REG_WDATA[4:2]))
    else $error("clamp field not written");
  a_therm_write: assert property (w6 |=> THERMAL_REG_THRESHOLD == $past(REG_WDATA[1:0]))
    else $error("threshold field not written");
  a_switch_write: assert property (w7 |=> BATTERY_SWITCH_OFF == $past(REG_WDATA[5]))
    else $error("switch bit not written");
  a_mohm_scale: assert property (IR_COMP_RESISTANCE_MOHM == 7'($past(IR_COMP_RESISTANCE)) * 7'h0a)
    else $error("resistance weight wrong");
  a_detect_rise: assert property ($rose(FORCE_PORT_DETECT) |-> $past(wd))
    else $error("detect set without write");
  a_int_cause: assert property (FAULT_INT |-> $past(CHARGE_FAULT_FLAG, 3) || $past(BATTERY_FAULT_FLAG, 3))
    else $error("interrupt without fault");
  a_read_data: assert property (REG_RD && !REG_WR && REG_ADDR == 8'h06 |=> REG_RDATA == $past(f6))
    else $error("readback mismatch");
  c_fault: cover property (FAULT_INT);
  c_detect_clear: cover property ($fell(FORCE_PORT_DETECT));
  c_misc_write: cover property (w7);
endmodule
bind ccmr_regs ccmr_assertions i_ccmr_assertions (.SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
  .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .CHARGE_FAULT_FLAG(CHARGE_FAULT_FLAG), .BATTERY_FAULT_FLAG(BATTERY_FAULT_FLAG),
  .IR_COMP_RESISTANCE(IR_COMP_RESISTANCE), .IR_COMP_RESISTANCE_MOHM(IR_COMP_RESISTANCE_MOHM),
  .IR_COMP_VOLTAGE_CLAMP(IR_COMP_VOLTAGE_CLAMP), .THERMAL_REG_THRESHOLD(THERMAL_REG_THRESHOLD),
  .FORCE_PORT_DETECT(FORCE_PORT_DETECT), .BATTERY_SWITCH_OFF(BATTERY_SWITCH_OFF), .FAULT_INT(FAULT_INT));

//--- tb/ccmr_host.sv
// Host model issuing register accesses.
// Assumes one access at a time, launched after a SYS_CLK edge.
`timescale 1ns/1ps
module ccmr_host (
  input  wire logic       SYS_CLK,
  input  wire logic [7:0] REG_RDATA,
  output logic      [7:0] REG_ADDR,
  output logic            REG_WR,
  output logic      [7:0] REG_WDATA,
  output logic            REG_RD
);
  initial {REG_ADDR, REG_WR, REG_WDATA, REG_RD} = 18'h0;
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_WDATA <= (a == 8'h07) ? {d[7:4], 2'b10, d[1:0]} : d;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  // One-cycle read strobe, data taken next edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    @(posedge SYS_CLK);
    d = REG_RDATA;
  endtask
endmodule

//--- tb/ccmr_regs_bench.sv
// Bench for the compensation and misc control registers.
// Assumes the host model drives the register port; the checker binds itself.
`timescale 1ns/1ps
module ccmr_regs_bench;
  logic       SYS_CLK = 1'b0;
  logic       RESET = 1'b1;
  logic [7:0] addr, wdata, rdata, v, reduce;
  logic       wr, rd, detect, sw_off, tick, fault_int;
  logic       done = 1'b0, cf = 1'b0, bf = 1'b0, lim = 1'b0, thr = 1'b0, warm = 1'b0;
  logic [6:0] mohm, mv, degc;
  int         miscompares = 0, check_count = 0, cyc = 0;
  ccmr_regs i_ccmr_regs (.SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
    .REG_RD(rd), .REG_RDATA(rdata), .DETECT_DONE(done), .CHARGE_FAULT_FLAG(cf), .BATTERY_FAULT_FLAG(bf),
    .INPUT_POWER_LIMITING(lim), .THERMAL_REGULATION(thr), .WARM_BAND(warm), .IR_COMP_RESISTANCE(),
    .IR_COMP_RESISTANCE_MOHM(mohm), .IR_COMP_VOLTAGE_CLAMP(), .IR_COMP_CLAMP_MV(mv), .THERMAL_REG_THRESHOLD(),
    .THERMAL_THRESHOLD_DEGC(degc), .FORCE_PORT_DETECT(detect), .BATTERY_SWITCH_OFF(sw_off),
    .CHARGE_VOLTAGE_REDUCE_MV(reduce), .SAFETY_TIMER_TICK(tick), .FAULT_INT(fault_int));
  ccmr_host i_ccmr_host (.SYS_CLK(SYS_CLK), .REG_RDATA(rdata), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RD(rd));
  initial forever #2 SYS_CLK = ~SYS_CLK;
  // Cycle ceiling against hangs
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 10000) begin
      miscompares++;
      stop_test;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    i_ccmr_host.rd(a, v);
    chk(v, exp);
  endtask
  task automatic do_reset;
    RESET <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    RESET <= 1'b0;
  endtask
  task automatic t_reset;
    rchk(8'h06, 8'h03);
    rchk(8'h07, 8'h4b);
    chk({1'b0, degc}, 8'h78);
    $display("reset test done");
  endtask
  task automatic t_comp(input logic [7:0] d, input logic [7:0] em, input logic [7:0] ev, input logic [7:0] et);
    i_ccmr_host.wr(8'h06, d);
    repeat (2) @(posedge SYS_CLK);
    chk({1'b0, mohm}, em);
    chk({1'b0, mv}, ev);
    chk({1'b0, degc}, et);
    i_ccmr_host.wr(8'h05, 8'hff);
    rchk(8'h05, 8'h00);
    rchk(8'h06, d);
    $display("compensation test done");
  endtask
  task automatic t_misc;
    i_ccmr_host.wr(8'h07, 8'h30);
    warm <= 1'b1;
    repeat (6) @(posedge SYS_CLK);
    chk({7'h0, sw_off}, 8'h01);
    chk(reduce, 8'hc8);
    rchk(8'h07, 8'h38);
    i_ccmr_host.wr(8'h07, 8'h0b);
    repeat (3) @(posedge SYS_CLK);
    chk({7'h0, sw_off}, 8'h00);
    chk(reduce, 8'h00);
    $display("misc test done");
  endtask
  task automatic t_detect;
    i_ccmr_host.wr(8'h07, 8'h8b);
    @(posedge SYS_CLK);
    chk({7'h0, detect}, 8'h01);
    done <= 1'b1;
    repeat (6) @(posedge SYS_CLK);
    done <= 1'b0;
    chk({7'h0, detect}, 8'h00);
    rchk(8'h07, 8'h0b);
    $display("detect test done");
  endtask
  task automatic fault_run(input logic charge, input logic [7:0] e);
    logic [7:0] n;
    n = 8'h0;
    if (charge) cf <= 1'b1;
    else bf <= 1'b1;
    repeat (12) begin
      @(posedge SYS_CLK);
      n = n + {7'h0, fault_int};
    end
    cf <= 1'b0;
    bf <= 1'b0;
    repeat (6) @(posedge SYS_CLK);
    chk(n, e);
  endtask
  task automatic t_fault(input logic [7:0] m, input logic [7:0] ec, input logic [7:0] eb);
    i_ccmr_host.wr(8'h07, m);
    fault_run(1'b1, ec);
    fault_run(1'b0, eb);
    $display("fault test done");
  endtask
  task automatic t_timer(input logic [7:0] m, input logic [1:0] s, input logic [7:0] e);
    logic [7:0] n;
    n = 8'h0;
    i_ccmr_host.wr(8'h07, m);
    {lim, thr} <= s;
    repeat (10) @(posedge SYS_CLK);
    repeat (1000) begin
      @(posedge SYS_CLK);
      n = n + {7'h0, tick};
    end
    chk(n, e);
    $display("timer test done");
  endtask
  task automatic stop_test;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    do_reset;
    t_reset;
    t_comp(8'hb6, 8'h32, 8'h50, 8'h64);
    t_comp(8'h4d, 8'h14, 8'h30, 8'h50);
    t_comp(8'hfc, 8'h46, 8'h70, 8'h3c);
    t_misc;
    t_detect;
    t_fault(8'h0b, 8'h01, 8'h01);
    t_fault(8'h08, 8'h00, 8'h00);
    t_fault(8'h0a, 8'h01, 8'h00);
    t_timer(8'h4b, 2'b10, 8'h02);
    t_timer(8'h4b, 2'b01, 8'h02);
    t_timer(8'h0b, 2'b11, 8'h04);
    t_timer(8'h4b, 2'b00, 8'h04);
    do_reset;
    t_reset;
    stop_test;
  end
endmodule
